// ==== verilog/gebs_pkg.sv ====
package gebs_pkg;
	// register offsets
	localparam logic [7:0] ADDR_LOADER_CTRL = 8'h56;
	localparam logic [7:0] ADDR_OPCODE = 8'h57;
	localparam logic [7:0] ADDR_START_HIGH = 8'h58;
	localparam logic [7:0] ADDR_START_MID = 8'h59;
	localparam logic [7:0] ADDR_START_LOW = 8'h5A;
	localparam logic [7:0] ADDR_BOOT_STATUS = 8'h5B;
	localparam logic [7:0] ADDR_BIQUAD_MARK = 8'h5C;
	localparam logic [7:0] ADDR_SUPPLY_CODE = 8'h5E;
	localparam logic [7:0] ADDR_PIN_DIR = 8'h60;
	localparam logic [7:0] ADDR_PIN0_SEL = 8'h61;
	localparam logic [7:0] ADDR_PIN1_SEL = 8'h62;
	localparam logic [7:0] ADDR_PIN2_SEL = 8'h63;
	localparam logic [7:0] ADDR_ROUTING = 8'h64;
	localparam logic [7:0] ADDR_USER_LEVEL = 8'h65;
	localparam logic [7:0] ADDR_INVERT = 8'h66;
	localparam logic [7:0] ADDR_DIE_IDENTIFICATION = 8'h67;
	localparam logic [7:0] ADDR_POWER_STATE = 8'h68;
	localparam logic [7:0] ADDR_SILENCE = 8'h69;

	localparam int NUM_PINS = 3;
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_OPCODE = 8'h03;
	// value is arbitrary
	localparam logic [7:0] DIE_IDENTIFICATION_DEFAULT = 8'h5A;

	// loader control fields
	localparam int LC_SOURCE_BIT = 0;
	localparam int LC_ORDER_BIT = 1;
	localparam int LC_EDGE_BIT = 2;
	localparam int LC_RATE_LSB = 3;
	localparam int LC_WIDE_BIT = 5;
	localparam logic [7:0] LC_USED_MASK = 8'h3F;
	localparam int BOOT_DONE_BIT = 0;
	localparam int BOOT_CRC_BIT = 1;
	localparam int ROUTE_MUTE_LSB = 0;
	localparam int ROUTE_RESET_LSB = 2;
	localparam int ROUTE_SYNC_LSB = 4;
	localparam int ROUTE_MISO_LSB = 6;

	// pin output selector codes
	localparam logic [3:0] SEL_LOW = 4'h0;
	localparam logic [3:0] SEL_USER = 4'h2;
	localparam logic [3:0] SEL_MUTE_BOTH = 4'h3;
	localparam logic [3:0] SEL_MUTE_LEFT = 4'h4;
	localparam logic [3:0] SEL_MUTE_RIGHT = 4'h5;
	localparam logic [3:0] SEL_CLK_BAD = 4'h6;
	localparam logic [3:0] SEL_WARN = 4'h8;
	localparam logic [3:0] SEL_SERIAL_AUDIO_OUT = 4'h9;
	localparam logic [3:0] SEL_SPI_CLK = 4'hB;
	localparam logic [3:0] SEL_MOSI_ALT = 4'hC;
	localparam logic [3:0] SEL_MOSI = 4'hD;
	localparam logic [1:0] ROUTE_NONE = 2'h0;

	// spi timing
	localparam int CLK_FREQ_KHZ = 250000;
	localparam int SPI_RATE_KHZ [4] = '{1250, 2500, 5000, 10000};
	localparam int COEF_BYTES = 16;
	localparam int HDR_BYTES_NARROW = 3;
	localparam int HDR_BYTES_WIDE = 4;
	localparam logic [7:0] CRC_POLY = 8'h07;

	typedef struct packed {
		logic wide;
		logic [1:0] rate;
		logic dataEdge;
		logic lsbFirst;
		logic [7:0] opcode;
		logic [23:0] startAddr;
	} gebs_loader_cfg_type;

	typedef struct packed {
		logic busy;
		logic done;
		logic crcFail;
	} gebs_loader_stat_type;

	// half spi period in clk cycles, rounded down so the rate never falls short
	function automatic logic [7:0] gebs_half_cycles(input logic [1:0] rate);
		return 8'(CLK_FREQ_KHZ / (2 * SPI_RATE_KHZ[rate]));
	endfunction

	function automatic logic [7:0] gebs_crc8(input logic [7:0] crc, input logic [7:0] data);
		logic [7:0] c;
		c = crc ^ data;
		for (int i = 0; i < 8; i++) begin
			c = c[7] ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
		end
		return c;
	endfunction
endpackage

// ==== verilog/gebs_spi_loader.sv ====
`timescale 1ns/100ps
module gebs_spi_loader import gebs_pkg::*; (
	input wire logic clk,
	input wire logic nrst,
	input wire logic start,
	input wire gebs_loader_cfg_type cfg,
	input wire logic misoIn,
	output logic sck,
	output logic mosi,
	output logic csN,
	output logic [7:0] coefData,
	output logic coefValid,
	output gebs_loader_stat_type stat
);
	typedef enum logic [1:0] {IDLE, SHIFT, FINISH} gebs_ldr_state_type;

	gebs_ldr_state_type state_ff;
	gebs_loader_cfg_type cfg_ff;
	logic [7:0] tick_ff, tx_ff, rx_ff, crc_ff, coefData_ff;
	logic [2:0] bitCnt_ff;
	logic [4:0] byteIdx_ff;
	logic samplePhase_ff, sck_ff, csN_ff, coefValid_ff, done_ff, crcFail_ff;

	wire logic tick = (tick_ff == 8'h00);
	wire logic [4:0] hdrBytes = cfg_ff.wide ? 5'(HDR_BYTES_WIDE) : 5'(HDR_BYTES_NARROW);
	wire logic [4:0] lastIdx = 5'(hdrBytes + 5'(COEF_BYTES));
	wire logic [7:0] rxNext = cfg_ff.lsbFirst ? {misoIn, rx_ff[7:1]} : {rx_ff[6:0], misoIn};
	wire logic byteEnd = tick && !samplePhase_ff && (bitCnt_ff == 3'h0);
	wire logic [4:0] nextIdx = 5'(byteIdx_ff + 5'h01);
	wire logic isData = (byteIdx_ff >= hdrBytes);
	// address goes out most significant byte first, high byte only in wide mode
	wire logic [7:0] nextTx = (nextIdx >= hdrBytes) ? RST_ZERO :
		(cfg_ff.wide && nextIdx == 5'h01) ? cfg_ff.startAddr[23:16] :
		(nextIdx == hdrBytes - 5'h02) ? cfg_ff.startAddr[15:8] : cfg_ff.startAddr[7:0];

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tick_ff <= RST_ZERO;
		end else if (state_ff != SHIFT || tick) begin
			tick_ff <= 8'(gebs_half_cycles(cfg_ff.rate) - 8'h01);
		end else begin
			tick_ff <= 8'(tick_ff - 8'h01);
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_ff <= IDLE;
			cfg_ff <= '0;
			tx_ff <= RST_ZERO;
			rx_ff <= RST_ZERO;
			crc_ff <= RST_ZERO;
			bitCnt_ff <= 3'h0;
			byteIdx_ff <= 5'h00;
			samplePhase_ff <= 1'b1;
			sck_ff <= 1'b0;
			csN_ff <= 1'b1;
			coefData_ff <= RST_ZERO;
			coefValid_ff <= 1'b0;
			done_ff <= 1'b0;
			crcFail_ff <= 1'b0;
		end else begin
			coefValid_ff <= 1'b0;
			done_ff <= 1'b0;
			unique case (state_ff)
				IDLE: begin
					if (start) begin
						state_ff <= SHIFT;
						cfg_ff <= cfg;
						tx_ff <= cfg.opcode;
						crc_ff <= RST_ZERO;
						crcFail_ff <= 1'b0;
						bitCnt_ff <= 3'h0;
						byteIdx_ff <= 5'h00;
						samplePhase_ff <= 1'b1;
						// idle level makes the first edge a sampling edge
						sck_ff <= ~cfg.dataEdge;
						csN_ff <= 1'b0;
					end
				end
				SHIFT: begin
					if (tick) begin
						sck_ff <= ~sck_ff;
						samplePhase_ff <= ~samplePhase_ff;
						if (samplePhase_ff) begin
							rx_ff <= rxNext;
							bitCnt_ff <= 3'(bitCnt_ff + 3'h1);
						end else if (byteEnd) begin
							byteIdx_ff <= nextIdx;
							tx_ff <= nextTx;
							if (isData && byteIdx_ff == lastIdx) begin
								crcFail_ff <= (rx_ff != crc_ff);
								state_ff <= FINISH;
							end else if (isData) begin
								crc_ff <= gebs_crc8(crc_ff, rx_ff);
								coefData_ff <= rx_ff;
								coefValid_ff <= 1'b1;
							end
						end else begin
							tx_ff <= cfg_ff.lsbFirst ? {1'b0, tx_ff[7:1]} : {tx_ff[6:0], 1'b0};
						end
					end
				end
				FINISH: begin
					csN_ff <= 1'b1;
					sck_ff <= ~cfg_ff.dataEdge;
					done_ff <= 1'b1;
					state_ff <= IDLE;
				end
			endcase
		end
	end

	assign sck = sck_ff;
	assign csN = csN_ff;
	assign mosi = cfg_ff.lsbFirst ? tx_ff[0] : tx_ff[7];
	assign coefData = coefData_ff;
	assign coefValid = coefValid_ff;
	assign stat = '{busy: (state_ff != IDLE), done: done_ff, crcFail: crcFail_ff};

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	first_bit_order_a: assert property (
		$fell(csN_ff) |-> mosi == (cfg_ff.lsbFirst ? cfg_ff.opcode[0] : cfg_ff.opcode[7]))
		else $error("first bit does not follow bit order");
	data_edge_a: assert property (
		state_ff == SHIFT && $past(state_ff) == SHIFT && $changed(mosi) |-> sck_ff == ~cfg_ff.dataEdge)
		else $error("data changed on the wrong clock edge");
	half_period_a: assert property (
		state_ff == SHIFT && $changed(sck_ff) ##1 state_ff == SHIFT |-> $stable(sck_ff)
		until (tick_ff == 8'h00))
		else $error("spi clock toggled early");
	load_cover_c: cover property (done_ff && !crcFail_ff);
endmodule

// ==== verilog/gebs_register_bank.sv ====
`timescale 1ns/100ps
// What this block does
// - loader control bit 1 picks spi bit order: 0 msb first, 1 lsb first
// - loader control bit 0 picks coefficient source: 0 host, 1 eeprom fetch
// - read opcode register, writable, resets to the common read command
// - high, middle, low bytes form the eeprom start address, high is msb
// - boot status bit 0 set once the eeprom boot load completes
// - boot status bit 1 reports crc: 0 pass, 1 fail
// - host sets biquad marker bit 0 before a biquad's first coefficient
// - supply voltage read back as read-only 8-bit adc code
// - per pin direction bits 0 to 2: 0 input, 1 output
// - selectors: low, user value, both/left/right mute flags, clock invalid
// - selector codes for warning output, serial audio out, loader spi clock
// - mosi code 1101 on two pins, 1100 on pin 1; other codes reserved
// - four 2-bit selectors route pins to miso, sync, reset and mute inputs
// - routed mute input low forces driver high impedance and stops switching
// - routed reset input leaves the input routing register untouched
// - user level bits drive pins whose selector holds the user code
// - inversion bits flip each pin's output level
// - read-only fixed die identification code
// - read-only power state: deep sleep, sleep, high impedance, play
// - wide address bit sends all three start address bytes after opcode
// - 2-bit rate field: 1.25, 2.5, 5 or 10 MHz spi clock
// - polarity bit: data changes on rising (0) or falling (1) edge
module gebs_register_bank import gebs_pkg::*; #(
	parameter logic [7:0] DIE_IDENTIFICATION_CODE = DIE_IDENTIFICATION_DEFAULT
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWdata,
	output logic [7:0] regRdata,
	output logic regRvalid,
	input wire logic leftSilenceMuted,
	input wire logic rightSilenceMuted,
	input wire logic clockInvalid,
	input wire logic warningOutN,
	input wire logic serialAudioOut,
	input wire logic [7:0] supplyVoltageCode,
	input wire logic [7:0] powerStateReport,
	input wire logic [NUM_PINS-1:0] pinIn,
	output logic [NUM_PINS-1:0] pinOut,
	output logic [NUM_PINS-1:0] pinOe,
	output logic ampMute,
	output logic routedResetN,
	output logic phaseSync,
	output logic biquadFirstCoefFlag,
	output logic coefFromEeprom,
	output logic [7:0] coefData,
	output logic coefValid
);
	logic [7:0] loaderCtrl_ff, opcode_ff, addrHigh_ff, addrMid_ff, addrLow_ff, routing_ff;
	logic [7:0] regRdata_ff;
	logic [NUM_PINS-1:0] dir_ff, user_ff, inv_ff, pinOut_ff, pinOe_ff;
	logic [NUM_PINS-1:0] pinSync1_ff, pinSync2_ff;
	logic [3:0] sel_ff [NUM_PINS];
	logic bqMark_ff, bootDone_ff, bootCrc_ff, regRvalid_ff;
	logic ampMute_ff, routedResetN_ff, phaseSync_ff, coefFromEeprom_ff;
	logic spiSck, spiMosi, spiCsN;
	gebs_loader_stat_type ldrStat;

	// a routed input with nothing selected idles at its inactive level
	function automatic logic pickPin(input logic [1:0] src, input logic [NUM_PINS-1:0] pins,
		input logic idle);
		return (src == ROUTE_NONE) ? idle : pins[2'(src - 2'h1)];
	endfunction

	// reserved codes fall through to a driven low
	function automatic logic outLevel(input logic [3:0] code, input logic [3:0] mosiCode,
		input logic user);
		logic lvl;
		lvl = 1'b0;
		if (code == SEL_USER) lvl = user;
		else if (code == SEL_MUTE_BOTH) lvl = leftSilenceMuted && rightSilenceMuted;
		else if (code == SEL_MUTE_LEFT) lvl = leftSilenceMuted;
		else if (code == SEL_MUTE_RIGHT) lvl = rightSilenceMuted;
		else if (code == SEL_CLK_BAD) lvl = clockInvalid;
		else if (code == SEL_WARN) lvl = warningOutN;
		else if (code == SEL_SERIAL_AUDIO_OUT) lvl = serialAudioOut;
		else if (code == SEL_SPI_CLK) lvl = spiSck;
		else if (code == mosiCode) lvl = spiMosi;
		return lvl;
	endfunction

	// write decode
	wire logic wrCtrl = regWr && regAddr == ADDR_LOADER_CTRL;
	wire logic wrOpcode = regWr && regAddr == ADDR_OPCODE;
	wire logic wrHigh = regWr && regAddr == ADDR_START_HIGH;
	wire logic wrMid = regWr && regAddr == ADDR_START_MID;
	wire logic wrLow = regWr && regAddr == ADDR_START_LOW;
	wire logic wrBq = regWr && regAddr == ADDR_BIQUAD_MARK;
	wire logic wrDir = regWr && regAddr == ADDR_PIN_DIR;
	wire logic wrRoute = regWr && regAddr == ADDR_ROUTING;
	wire logic wrUser = regWr && regAddr == ADDR_USER_LEVEL;
	wire logic wrInv = regWr && regAddr == ADDR_INVERT;
	wire logic [NUM_PINS-1:0] wrSel = {regWr && regAddr == ADDR_PIN2_SEL,
		regWr && regAddr == ADDR_PIN1_SEL, regWr && regAddr == ADDR_PIN0_SEL};

	wire logic muteLevel = pickPin(routing_ff[ROUTE_MUTE_LSB+:2], pinSync2_ff, 1'b1);
	wire logic resetLevel = pickPin(routing_ff[ROUTE_RESET_LSB+:2], pinSync2_ff, 1'b1);
	wire logic syncLevel = pickPin(routing_ff[ROUTE_SYNC_LSB+:2], pinSync2_ff, 1'b0);
	wire logic misoLevel = pickPin(routing_ff[ROUTE_MISO_LSB+:2], pinSync2_ff, 1'b0);
	// the pin reset is qualified by the routing register it must not clear
	wire logic softRst = !resetLevel;

	// a fresh 0 to 1 of the source bit starts one fetch
	wire logic ldrStart = wrCtrl && regWdata[LC_SOURCE_BIT] && !loaderCtrl_ff[LC_SOURCE_BIT]
		&& !ldrStat.busy;
	wire gebs_loader_cfg_type ldrCfg = '{
		wide: loaderCtrl_ff[LC_WIDE_BIT],
		rate: loaderCtrl_ff[LC_RATE_LSB+:2],
		dataEdge: loaderCtrl_ff[LC_EDGE_BIT],
		lsbFirst: loaderCtrl_ff[LC_ORDER_BIT],
		opcode: opcode_ff,
		startAddr: {addrHigh_ff, addrMid_ff, addrLow_ff}};

	function automatic logic [7:0] readMux(input logic [7:0] a);
		logic [7:0] d;
		d = RST_ZERO;
		if (a == ADDR_LOADER_CTRL) d = loaderCtrl_ff;
		else if (a == ADDR_OPCODE) d = opcode_ff;
		else if (a == ADDR_START_HIGH) d = addrHigh_ff;
		else if (a == ADDR_START_MID) d = addrMid_ff;
		else if (a == ADDR_START_LOW) d = addrLow_ff;
		else if (a == ADDR_BOOT_STATUS) d = 8'({bootCrc_ff, bootDone_ff});
		else if (a == ADDR_BIQUAD_MARK) d = 8'(bqMark_ff);
		else if (a == ADDR_SUPPLY_CODE) d = supplyVoltageCode;
		else if (a == ADDR_PIN_DIR) d = 8'(dir_ff);
		else if (a == ADDR_PIN0_SEL) d = 8'(sel_ff[0]);
		else if (a == ADDR_PIN1_SEL) d = 8'(sel_ff[1]);
		else if (a == ADDR_PIN2_SEL) d = 8'(sel_ff[2]);
		else if (a == ADDR_ROUTING) d = routing_ff;
		else if (a == ADDR_USER_LEVEL) d = 8'(user_ff);
		else if (a == ADDR_INVERT) d = 8'(inv_ff);
		else if (a == ADDR_DIE_IDENTIFICATION) d = DIE_IDENTIFICATION_CODE;
		else if (a == ADDR_POWER_STATE) d = powerStateReport;
		else if (a == ADDR_SILENCE) d = 8'({rightSilenceMuted, leftSilenceMuted});
		return d;
	endfunction
	// always_comb so the mux follows the registers it reads, not only the address
	logic [7:0] nxt_regRdata;
	always_comb nxt_regRdata = readMux(regAddr);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pinSync1_ff <= '0;
			pinSync2_ff <= '0;
		end else begin
			pinSync1_ff <= pinIn;
			pinSync2_ff <= pinSync1_ff;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			routing_ff <= RST_ZERO;
		end else if (wrRoute) begin
			routing_ff <= regWdata;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			loaderCtrl_ff <= RST_ZERO;
			opcode_ff <= RST_OPCODE;
			addrHigh_ff <= RST_ZERO;
			addrMid_ff <= RST_ZERO;
			addrLow_ff <= RST_ZERO;
			bqMark_ff <= 1'b0;
		end else if (softRst) begin
			loaderCtrl_ff <= RST_ZERO;
			opcode_ff <= RST_OPCODE;
			addrHigh_ff <= RST_ZERO;
			addrMid_ff <= RST_ZERO;
			addrLow_ff <= RST_ZERO;
			bqMark_ff <= 1'b0;
		end else begin
			if (wrCtrl) loaderCtrl_ff <= regWdata & LC_USED_MASK;
			if (wrOpcode) opcode_ff <= regWdata;
			if (wrHigh) addrHigh_ff <= regWdata;
			if (wrMid) addrMid_ff <= regWdata;
			if (wrLow) addrLow_ff <= regWdata;
			if (wrBq) bqMark_ff <= regWdata[0];
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			dir_ff <= '0;
			user_ff <= '0;
			inv_ff <= '0;
		end else if (softRst) begin
			dir_ff <= '0;
			user_ff <= '0;
			inv_ff <= '0;
		end else begin
			if (wrDir) dir_ff <= regWdata[NUM_PINS-1:0];
			if (wrUser) user_ff <= regWdata[NUM_PINS-1:0];
			if (wrInv) inv_ff <= regWdata[NUM_PINS-1:0];
		end
	end

	// done and crc status, cleared only when a new fetch starts
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			bootDone_ff <= 1'b0;
			bootCrc_ff <= 1'b0;
		end else if (ldrStat.done) begin
			bootDone_ff <= 1'b1;
			bootCrc_ff <= ldrStat.crcFail;
		end else if (ldrStart) begin
			bootDone_ff <= 1'b0;
			bootCrc_ff <= 1'b0;
		end
	end

	genvar p;
	generate
		for (p = 0; p < NUM_PINS; p++) begin : g_pin
			// pin 1 answers the alternate mosi code
			localparam logic [3:0] MOSI_CODE = (p == 1) ? SEL_MOSI_ALT : SEL_MOSI;
			// output selection
			// the function reads status and spi lines that are not arguments
			logic level;
			always_comb level = outLevel(sel_ff[p], MOSI_CODE, user_ff[p]);
			always_ff @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					sel_ff[p] <= 4'h0;
					pinOut_ff[p] <= 1'b0;
					pinOe_ff[p] <= 1'b0;
				end else begin
					if (softRst) sel_ff[p] <= 4'h0;
					else if (wrSel[p]) sel_ff[p] <= regWdata[3:0];
					pinOut_ff[p] <= level ^ inv_ff[p];
					pinOe_ff[p] <= dir_ff[p];
				end
			end
		end
	endgenerate

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			regRdata_ff <= RST_ZERO;
			regRvalid_ff <= 1'b0;
			ampMute_ff <= 1'b0;
			routedResetN_ff <= 1'b1;
			phaseSync_ff <= 1'b0;
			coefFromEeprom_ff <= 1'b0;
		end else begin
			regRvalid_ff <= regRd;
			if (regRd) regRdata_ff <= nxt_regRdata;
			// mute forces high impedance and stops switching
			ampMute_ff <= !muteLevel;
			routedResetN_ff <= resetLevel;
			phaseSync_ff <= syncLevel;
			coefFromEeprom_ff <= loaderCtrl_ff[LC_SOURCE_BIT];
		end
	end

	gebs_spi_loader u_loader (
		.clk(clk),
		.nrst(nrst),
		.start(ldrStart),
		.cfg(ldrCfg),
		.misoIn(misoLevel),
		.sck(spiSck),
		.mosi(spiMosi),
		.csN(spiCsN),
		.coefData(coefData),
		.coefValid(coefValid),
		.stat(ldrStat)
	);

	assign regRdata = regRdata_ff;
	assign regRvalid = regRvalid_ff;
	assign pinOut = pinOut_ff;
	assign pinOe = pinOe_ff;
	assign ampMute = ampMute_ff;
	assign routedResetN = routedResetN_ff;
	assign phaseSync = phaseSync_ff;
	assign biquadFirstCoefFlag = bqMark_ff;
	assign coefFromEeprom = coefFromEeprom_ff;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	die_identification_read_a: assert property (
		regRd && regAddr == ADDR_DIE_IDENTIFICATION |=> regRvalid_ff && regRdata_ff == DIE_IDENTIFICATION_CODE)
		else $error("die_identification read wrong");
	opcode_write_a: assert property (
		wrOpcode && !softRst ##1 !wrOpcode && !softRst
		##1 regRd && regAddr == ADDR_OPCODE && !wrOpcode && !softRst
		|=> regRdata_ff == $past(regWdata, 3))
		else $error("opcode readback wrong");
	reserved_zero_a: assert property (
		regRd && regAddr == ADDR_USER_LEVEL |=> regRdata_ff[7:NUM_PINS] == '0)
		else $error("reserved bits not zero");
	pin_dir_a: assert property (
		##1 pinOe_ff == $past(dir_ff))
		else $error("pin direction not followed");
	pin_user_a: assert property (
		sel_ff[0] == SEL_USER |=> pinOut_ff[0] == ($past(user_ff[0]) ^ $past(inv_ff[0])))
		else $error("user level not driven");
	pin_low_inv_a: assert property (
		sel_ff[2] == SEL_LOW |=> pinOut_ff[2] == $past(inv_ff[2]))
		else $error("off level not inverted");
	mute_route_a: assert property (
		routing_ff[ROUTE_MUTE_LSB+:2] != ROUTE_NONE && !muteLevel |=> ampMute_ff)
		else $error("mute not applied");
	route_keep_a: assert property (
		softRst && !wrRoute |=> $stable(routing_ff))
		else $error("routing cleared by pin reset");
	fetch_start_a: assert property (
		ldrStart |-> ##[1:2] !spiCsN)
		else $error("chip select not asserted");
	boot_done_a: assert property (
		ldrStat.done |=> bootDone_ff && bootCrc_ff == $past(ldrStat.crcFail))
		else $error("boot status not set");

	fetch_cover_c: cover property (ldrStart ##[1:1000] !spiCsN);
	crc_fail_cover_c: cover property (ldrStat.done && ldrStat.crcFail);
	mute_cover_c: cover property ($rose(ampMute_ff));
	mosi_alt_cover_c: cover property (sel_ff[1] == SEL_MOSI_ALT && !spiCsN);
endmodule

// ==== dv/gebs_eeprom_model.sv ====
`timescale 1ns/100ps
module gebs_eeprom_model (
	input wire logic sck,
	input wire logic mosi,
	input wire logic dataEdge,
	input wire logic frameStart,
	input wire logic fillOnes,
	input wire logic [5:0] hdrBits,
	output logic miso,
	output logic [31:0] hdr
);
	int cnt;
	initial begin
		miso = 1'b0;
		hdr = '0;
		cnt = 0;
	end
	always @(posedge frameStart) begin
		cnt = 0;
		hdr = '0;
	end
	// sampling edge is the one on which data does not change
	always @(sck) begin
		if (sck === dataEdge) begin
			// opcode then address, shifted in as sent
			if (cnt < hdrBits) begin
				hdr = {hdr[30:0], mosi};
			end
			cnt = cnt + 1;
		end else begin
			// not driven during the header, so the line toggles instead of holding
			miso = (cnt < hdrBits) ? cnt[0] : fillOnes;
		end
	end
endmodule

// ==== dv/tb_gebs_register_bank.sv ====
`timescale 1ns/100ps
module tb_gebs_register_bank;
	import gebs_pkg::*;
	logic clk, nrst, regWr, regRd, regRvalid, miso, frameStart, fillOnes, dataEdge;
	logic ampMute, routedResetN, phaseSync, bqFlag, fromEe, coefValid;
	logic leftM, rightM, clkBad, warnN, sdo;
	logic [7:0] regAddr, regWdata, regRdata, coefData, rdv, supply, pstate;
	logic [2:0] pinOut, pinOe, pinIn, extDrv;
	logic [5:0] hdrBits;
	logic [31:0] hdr;
	int err_count, n_checks, coefCnt;
	localparam logic [31:0] ROWS [29] = '{32'h0056_0000, 32'h0057_0003, 32'h0058_0000,
		32'h0059_0000, 32'h005A_0000, 32'h005B_0000, 32'h005C_0000, 32'h0060_0000,
		32'h0061_0000, 32'h0064_0000, 32'h0065_0000, 32'h0066_0000, 32'h0067_00A6,
		32'h005E_00DF, 32'h0068_0003, 32'h0069_0001, 32'h0157_A5A5, 32'h0158_1212,
		32'h015B_FF00, 32'h015E_00DF, 32'h0167_00A6, 32'h0168_0003, 32'h015D_FF00,
		32'h015C_FF01, 32'h0160_FF07, 32'h0161_FF0F, 32'h0165_FF07, 32'h0166_FF07,
		32'h0156_FE3E};
	localparam logic [7:0] SELS [13] = '{8'h00, 8'h21, 8'h30, 8'h41, 8'h50, 8'h61, 8'h80,
		8'h91, 8'hB0, 8'h10, 8'h70, 8'hE0, 8'hF0};
	// a pin the block drives reads back its own level
	assign pinIn = (pinOe & pinOut) | (~pinOe & {extDrv[2], (hdrBits != 0) ? miso : extDrv[1],
		extDrv[0]});
	gebs_register_bank #(.DIE_IDENTIFICATION_CODE(8'hA6)) i_gebs_register_bank (.clk(clk), .nrst(nrst),
		.regWr(regWr), .regRd(regRd), .regAddr(regAddr), .regWdata(regWdata),
		.regRdata(regRdata), .regRvalid(regRvalid), .leftSilenceMuted(leftM),
		.rightSilenceMuted(rightM), .clockInvalid(clkBad), .warningOutN(warnN),
		.serialAudioOut(sdo), .supplyVoltageCode(supply), .powerStateReport(pstate),
		.pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .ampMute(ampMute),
		.routedResetN(routedResetN), .phaseSync(phaseSync), .biquadFirstCoefFlag(bqFlag),
		.coefFromEeprom(fromEe), .coefData(coefData), .coefValid(coefValid));
	gebs_eeprom_model i_gebs_eeprom_model (.sck(pinOut[0]), .mosi(pinOut[2]),
		.dataEdge(dataEdge), .frameStart(frameStart), .fillOnes(fillOnes),
		.hdrBits(hdrBits), .miso(miso), .hdr(hdr));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) if (coefValid === 1'b1) coefCnt <= coefCnt + 1;
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			$display("unexpected %s expected %h seen %h", nm, e, g);
			err_count++;
		end
	endtask
	task stop_test();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge clk);
		regWr <= 1'b0;
	endtask
	task rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		regRd <= 1'b0;
		#1;
		d = (regRvalid === 1'b1) ? regRdata : 8'hxx;
	endtask
	task fetch(input logic [7:0] ctrl, input logic fill, input logic [5:0] bits,
		input logic [31:0] expHdr, input logic [7:0] expStat);
		int base;
		wr(ADDR_LOADER_CTRL, ctrl);
		settle(1);
		fillOnes <= fill;
		dataEdge <= ctrl[LC_EDGE_BIT];
		hdrBits <= bits;
		frameStart <= 1'b1;
		settle(1);
		frameStart <= 1'b0;
		base = coefCnt;
		wr(ADDR_LOADER_CTRL, ctrl | 8'h01);
		rdv = 8'h00;
		for (int i = 0; i < 5000 && rdv[BOOT_DONE_BIT] !== 1'b1; i++) rd(ADDR_BOOT_STATUS, rdv);
		if (rdv[BOOT_DONE_BIT] !== 1'b1) begin
			err_count++;
			stop_test();
		end else begin
			chk("boot status", {24'h0, expStat}, {24'h0, rdv});
			chk("header", expHdr, hdr);
			chk("coef count", 32'h0000_0010, coefCnt - base);
			chk("coef data", {24'h0, {8{fill}}}, {24'h0, coefData});
			chk("source", 32'h0000_0001, {31'h0, fromEe});
			hdrBits <= 6'h00;
			$display("test fetch %h done", ctrl);
		end
	endtask
	initial begin
		nrst = 1'b0;
		{regWr, regRd, frameStart, fillOnes, dataEdge} = '0;
		{regAddr, regWdata, hdrBits, coefCnt, err_count, n_checks} = '0;
		{leftM, rightM, clkBad, warnN, sdo} = 5'b10101;
		supply = 8'hDF;
		pstate = 8'h03;
		extDrv = 3'h7;
		settle(10);
		chk("reset outputs", 32'h0000_0001, {29'h0, pinOe, routedResetN});
		@(posedge clk);
		nrst <= 1'b1;
		foreach (ROWS[i]) begin
			if (ROWS[i][24] === 1'b1) wr(ROWS[i][23:16], ROWS[i][15:8]);
			rd(ROWS[i][23:16], rdv);
			chk("register", {24'h0, ROWS[i][7:0]}, {24'h0, rdv});
		end
		chk("biquad flag", 32'h0000_0001, {31'h0, bqFlag});
		$display("test registers done");
		wr(ADDR_USER_LEVEL, 8'h01);
		wr(ADDR_PIN_DIR, 8'h01);
		for (int v = 0; v < 2; v++) begin
			wr(ADDR_INVERT, 8'(v));
			foreach (SELS[i]) begin
				wr(ADDR_PIN0_SEL, {4'h0, SELS[i][7:4]});
				settle(3);
				chk("pin0 level", {31'h0, SELS[i][0] ^ v[0]}, {31'h0, pinOut[0]});
			end
		end
		chk("pin enables", 32'h0000_0001, {29'h0, pinOe});
		wr(ADDR_ROUTING, 8'h02);
		extDrv[1] <= 1'b0;
		settle(5);
		chk("mute on", 32'h0000_0001, {31'h0, ampMute});
		extDrv[1] <= 1'b1;
		settle(5);
		chk("mute off", 32'h0000_0000, {31'h0, ampMute});
		$display("test pins done");
		wr(ADDR_OPCODE, 8'h0B);
		wr(ADDR_START_HIGH, 8'h12);
		wr(ADDR_START_MID, 8'h34);
		wr(ADDR_START_LOW, 8'h56);
		wr(ADDR_PIN0_SEL, {4'h0, SEL_SPI_CLK});
		wr(ADDR_PIN2_SEL, {4'h0, SEL_MOSI});
		wr(ADDR_PIN_DIR, 8'h05);
		wr(ADDR_INVERT, 8'h00);
		wr(ADDR_ROUTING, 8'h80);
		fetch(8'h38, 1'b0, 6'd32, 32'h0B12_3456, 8'h01);
		fetch(8'h1E, 1'b1, 6'd24, 32'h00D0_2C6A, 8'h03);
		wr(ADDR_ROUTING, 8'h28);
		wr(ADDR_OPCODE, 8'h77);
		extDrv[1] <= 1'b0;
		settle(5);
		chk("routed reset", 32'h0000_0000, {31'h0, routedResetN});
		rd(ADDR_OPCODE, rdv);
		chk("opcode after reset", 32'h0000_0003, {24'h0, rdv});
		rd(ADDR_ROUTING, rdv);
		chk("routing kept", 32'h0000_0028, {24'h0, rdv});
		chk("sync low", 32'h0000_0000, {31'h0, phaseSync});
		extDrv[1] <= 1'b1;
		settle(5);
		chk("sync high", 32'h0000_0001, {31'h0, phaseSync});
		$display("test routed reset done");
		stop_test();
	end
endmodule
